// ### include/appb_params.svh
/*
  Offsets, field limits, reset values and voltage tables of the parameter bank.
  Assumes a plain register port whose address is the register number itself.
*/
`ifndef APPB_PARAMS_SVH
`define APPB_PARAMS_SVH

`define APPB_ADDR_W 8
`define APPB_DATA_W 16
`define APPB_NREG 23

`define APPB_ADDR_BASE 8'h72
`define APPB_ADDR_VREG_MODE 8'h72
`define APPB_ADDR_VREG_SEL 8'h73
`define APPB_ADDR_SECOND_ACCEL_PROFILE_HI_M1 8'h74
`define APPB_ADDR_SECOND_ACCEL_PROFILE_LO_M1 8'h75
`define APPB_ADDR_SECOND_ACCEL_PROFILE_HI_M2 8'h76
`define APPB_ADDR_SECOND_ACCEL_PROFILE_LO_M2 8'h77
`define APPB_ADDR_SECOND_DECEL_PROFILE_HI_M1 8'h78
`define APPB_ADDR_SECOND_DECEL_PROFILE_LO_M1 8'h79
`define APPB_ADDR_SECOND_DECEL_PROFILE_HI_M2 8'h7a
`define APPB_ADDR_SECOND_DECEL_PROFILE_LO_M2 8'h7b
`define APPB_ADDR_SW_M1 8'h7c
`define APPB_ADDR_SW_M2 8'h7d
`define APPB_ADDR_ACC_TR_M1 8'h7e
`define APPB_ADDR_ACC_TR_M2 8'h7f
`define APPB_ADDR_DEC_TR_M1 8'h80
`define APPB_ADDR_DEC_TR_M2 8'h81
`define APPB_ADDR_ACC_CURVE 8'h82
`define APPB_ADDR_DEC_CURVE 8'h83
`define APPB_ADDR_CI_FS 8'h84
`define APPB_ADDR_CI_FE 8'h85
`define APPB_ADDR_CI_PS 8'h86
`define APPB_ADDR_CI_PE 8'h87
`define APPB_ADDR_CI_SSEL 8'h88
`define APPB_ADDR_CALC_A 8'he3

// Legal ranges
`define APPB_MAX_MODE 32'h2
`define APPB_MAX_VSEL_200 32'h4
`define APPB_MAX_VSEL_400 32'h5
`define APPB_MIN_TIME 32'h1
`define APPB_MAX_TIME 32'h493e0
`define APPB_MAX_BIT 32'h1
`define APPB_MAX_FREQ 32'hfa0
`define APPB_MAX_PCT 32'h64
`define APPB_MAX_SRC 32'h4
`define APPB_TIME_COARSE 32'h2710
`define APPB_TIME_DIGIT 32'ha

// Reset values
`define APPB_RST_MODE 16'h0
`define APPB_RST_VSEL 16'h0
`define APPB_RST_TIME_HI 16'h0
`define APPB_RST_TIME_LO 16'h3e8
`define APPB_RST_BIT 16'h0
`define APPB_RST_FREQ 16'h0
`define APPB_RST_PCT_S 16'h0
`define APPB_RST_PCT_E 16'h64
`define APPB_RST_SRC 16'h0

// Regulated voltages in volts
`define APPB_V200_0 9'hc8
`define APPB_V200_1 9'hd7
`define APPB_V200_2 9'hdc
`define APPB_V200_3 9'he6
`define APPB_V200_4 9'hf0
`define APPB_V400_0 9'h17c
`define APPB_V400_1 9'h190
`define APPB_V400_2 9'h19f
`define APPB_V400_3 9'h1b8
`define APPB_V400_4 9'h1cc
`define APPB_V400_5 9'h1e0

`endif

// ### include/appb_pkg.sv
/*
  Types of the parameter bank: register array and state record.
  Assumes appb_params.svh is on the include path.
*/
`include "appb_params.svh"
package appb_pkg;

  typedef logic [`APPB_DATA_W-1:0] appb_word_t;

  typedef struct packed {
    appb_word_t [`APPB_NREG-1:0] regs;
    appb_word_t calc_src;
    appb_word_t rdata;
    logic [1:0] term_sync;
    logic [1:0] class_sync;
    logic [8:0] volts;
    logic [18:0] second_accel_profile_time;
    logic [18:0] second_decel_profile_time;
    logic use_second_accel_profile;
    logic use_second_decel_profile;
    logic [11:0] scaled_freq;
  } appb_state_t;

endpackage : appb_pkg

// ### rtl/appb_range_chk.sv
/*
  Range check of one candidate register value against inclusive bounds.
  Assumes bounds are chosen by the caller for the addressed register.
*/
module appb_range_chk (
  input wire logic [31:0] value,
  input wire logic [31:0] lo_lim,
  input wire logic [31:0] hi_lim,
  output logic ok
);

  assign ok = (value >= lo_lim) && (value <= hi_lim);

endmodule : appb_range_chk

// ### rtl/appb_bank.sv
/*
  Holding-register bank for output voltage regulation, second ramp segments,
  profile switching, ramp curves, current-input scaling and calc operand source.
  Assumes a single-cycle register port on clk; pins are synchronised here,
  frequency, percent and motor selection come from logic on clk.
*/
`include "appb_params.svh"
module appb_bank
  import appb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`APPB_ADDR_W-1:0] addr,
  input wire logic [`APPB_DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [`APPB_DATA_W-1:0] rdata,
  input wire logic class_400_pin,
  input wire logic profile_select_terminal,
  input wire logic motor2_sel,
  input wire logic [11:0] out_freq,
  input wire logic [6:0] current_input_terminal,
  output logic regulation_active,
  output logic regulation_off_in_decel,
  output logic [8:0] regulated_volts,
  output logic [18:0] second_accel_time,
  output logic [18:0] second_decel_time,
  output logic use_second_accel,
  output logic use_second_decel,
  output logic accel_s_curve,
  output logic decel_s_curve,
  output logic [11:0] scaled_freq,
  output logic [4:0] first_operand_source
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  localparam int unsigned IDX_W = 5;

  function automatic logic [IDX_W-1:0] idx(input logic [`APPB_ADDR_W-1:0] a);
    logic [`APPB_ADDR_W-1:0] d;
    d = a - `APPB_ADDR_BASE;
    return d[IDX_W-1:0];
  endfunction : idx

  function automatic appb_state_t rst_state();
    appb_state_t s;
    s = '0;
    s.regs[idx(`APPB_ADDR_VREG_MODE)] = `APPB_RST_MODE;
    s.regs[idx(`APPB_ADDR_VREG_SEL)] = `APPB_RST_VSEL;
    s.regs[idx(`APPB_ADDR_SECOND_ACCEL_PROFILE_HI_M1)] = `APPB_RST_TIME_HI;
    s.regs[idx(`APPB_ADDR_SECOND_ACCEL_PROFILE_LO_M1)] = `APPB_RST_TIME_LO;
    s.regs[idx(`APPB_ADDR_SECOND_ACCEL_PROFILE_HI_M2)] = `APPB_RST_TIME_HI;
    s.regs[idx(`APPB_ADDR_SECOND_ACCEL_PROFILE_LO_M2)] = `APPB_RST_TIME_LO;
    s.regs[idx(`APPB_ADDR_SECOND_DECEL_PROFILE_HI_M1)] = `APPB_RST_TIME_HI;
    s.regs[idx(`APPB_ADDR_SECOND_DECEL_PROFILE_LO_M1)] = `APPB_RST_TIME_LO;
    s.regs[idx(`APPB_ADDR_SECOND_DECEL_PROFILE_HI_M2)] = `APPB_RST_TIME_HI;
    s.regs[idx(`APPB_ADDR_SECOND_DECEL_PROFILE_LO_M2)] = `APPB_RST_TIME_LO;
    s.regs[idx(`APPB_ADDR_SW_M1)] = `APPB_RST_BIT;
    s.regs[idx(`APPB_ADDR_SW_M2)] = `APPB_RST_BIT;
    s.regs[idx(`APPB_ADDR_ACC_TR_M1)] = `APPB_RST_FREQ;
    s.regs[idx(`APPB_ADDR_ACC_TR_M2)] = `APPB_RST_FREQ;
    s.regs[idx(`APPB_ADDR_DEC_TR_M1)] = `APPB_RST_FREQ;
    s.regs[idx(`APPB_ADDR_DEC_TR_M2)] = `APPB_RST_FREQ;
    s.regs[idx(`APPB_ADDR_ACC_CURVE)] = `APPB_RST_BIT;
    s.regs[idx(`APPB_ADDR_DEC_CURVE)] = `APPB_RST_BIT;
    s.regs[idx(`APPB_ADDR_CI_FS)] = `APPB_RST_FREQ;
    s.regs[idx(`APPB_ADDR_CI_FE)] = `APPB_RST_FREQ;
    s.regs[idx(`APPB_ADDR_CI_PS)] = `APPB_RST_PCT_S;
    s.regs[idx(`APPB_ADDR_CI_PE)] = `APPB_RST_PCT_E;
    s.regs[idx(`APPB_ADDR_CI_SSEL)] = `APPB_RST_BIT;
    s.calc_src = `APPB_RST_SRC;
    s.volts = `APPB_V200_0;
    s.second_accel_profile_time = 19'(`APPB_RST_TIME_LO);
    s.second_decel_profile_time = 19'(`APPB_RST_TIME_LO);
    return s;
  endfunction : rst_state

  localparam appb_state_t RST_STATE = rst_state();

  appb_state_t st_ff;
  appb_state_t nxt_st;

  function automatic appb_word_t rg(input appb_state_t s, input logic [`APPB_ADDR_W-1:0] a);
    return s.regs[idx(a)];
  endfunction : rg

  // ---------------------------------------------------------------
  // Write qualification
  // ---------------------------------------------------------------
  logic mapped;
  logic cls400;
  logic [31:0] cand;
  logic [31:0] lo_lim;
  logic [31:0] hi_lim;
  logic wr_ok;

  assign cls400 = st_ff.class_sync[1];
  assign mapped = (addr == `APPB_ADDR_CALC_A) ||
                  ((addr >= `APPB_ADDR_BASE) && (addr <= `APPB_ADDR_CI_SSEL));

  always_comb begin
    cand = {16'h0, wdata};
    lo_lim = 32'h0;
    hi_lim = `APPB_MAX_BIT;
    unique case (addr)
      `APPB_ADDR_VREG_MODE: hi_lim = `APPB_MAX_MODE;
      // Code 5 exists only for the 400 V class
      `APPB_ADDR_VREG_SEL: hi_lim = cls400 ? `APPB_MAX_VSEL_400 : `APPB_MAX_VSEL_200;
      // Either half is checked against the other stored half, so a pair
      // may have to be written in a particular order to stay legal
      `APPB_ADDR_SECOND_ACCEL_PROFILE_HI_M1, `APPB_ADDR_SECOND_ACCEL_PROFILE_HI_M2,
      `APPB_ADDR_SECOND_DECEL_PROFILE_HI_M1, `APPB_ADDR_SECOND_DECEL_PROFILE_HI_M2: begin
        cand = {wdata, st_ff.regs[idx(addr) + 5'h1]};
        lo_lim = `APPB_MIN_TIME;
        hi_lim = `APPB_MAX_TIME;
      end
      `APPB_ADDR_SECOND_ACCEL_PROFILE_LO_M1, `APPB_ADDR_SECOND_ACCEL_PROFILE_LO_M2,
      `APPB_ADDR_SECOND_DECEL_PROFILE_LO_M1, `APPB_ADDR_SECOND_DECEL_PROFILE_LO_M2: begin
        cand = {st_ff.regs[idx(addr) - 5'h1], wdata};
        lo_lim = `APPB_MIN_TIME;
        hi_lim = `APPB_MAX_TIME;
      end
      `APPB_ADDR_ACC_TR_M1, `APPB_ADDR_ACC_TR_M2,
      `APPB_ADDR_DEC_TR_M1, `APPB_ADDR_DEC_TR_M2,
      `APPB_ADDR_CI_FS, `APPB_ADDR_CI_FE: hi_lim = `APPB_MAX_FREQ;
      `APPB_ADDR_CI_PS, `APPB_ADDR_CI_PE: hi_lim = `APPB_MAX_PCT;
      `APPB_ADDR_CALC_A: hi_lim = `APPB_MAX_SRC;
      default: hi_lim = `APPB_MAX_BIT;
    endcase
  end

  appb_range_chk u_chk (
    .value(cand),
    .lo_lim(lo_lim),
    .hi_lim(hi_lim),
    .ok(wr_ok)
  );

  // ---------------------------------------------------------------
  // Derived values for the selected motor
  // ---------------------------------------------------------------
  logic [31:0] second_accel_profile_raw;
  logic [31:0] second_decel_profile_raw;
  logic [15:0] sw_method;
  logic [15:0] acc_tr;
  logic [15:0] dec_tr;
  logic [8:0] volts_dec;

  assign second_accel_profile_raw = motor2_sel ?
    {rg(st_ff, `APPB_ADDR_SECOND_ACCEL_PROFILE_HI_M2), rg(st_ff, `APPB_ADDR_SECOND_ACCEL_PROFILE_LO_M2)} :
    {rg(st_ff, `APPB_ADDR_SECOND_ACCEL_PROFILE_HI_M1), rg(st_ff, `APPB_ADDR_SECOND_ACCEL_PROFILE_LO_M1)};
  assign second_decel_profile_raw = motor2_sel ?
    {rg(st_ff, `APPB_ADDR_SECOND_DECEL_PROFILE_HI_M2), rg(st_ff, `APPB_ADDR_SECOND_DECEL_PROFILE_LO_M2)} :
    {rg(st_ff, `APPB_ADDR_SECOND_DECEL_PROFILE_HI_M1), rg(st_ff, `APPB_ADDR_SECOND_DECEL_PROFILE_LO_M1)};
  assign sw_method = motor2_sel ? rg(st_ff, `APPB_ADDR_SW_M2) : rg(st_ff, `APPB_ADDR_SW_M1);
  assign acc_tr = motor2_sel ? rg(st_ff, `APPB_ADDR_ACC_TR_M2) :
                               rg(st_ff, `APPB_ADDR_ACC_TR_M1);
  assign dec_tr = motor2_sel ? rg(st_ff, `APPB_ADDR_DEC_TR_M2) :
                               rg(st_ff, `APPB_ADDR_DEC_TR_M1);

  // Long ramps lose the hundredths digit
  function automatic logic [18:0] coarse(input logic [31:0] t);
    logic [31:0] r;
    r = t;
    if (t >= `APPB_TIME_COARSE) begin
      r = t - (t % `APPB_TIME_DIGIT);
    end
    return r[18:0];
  endfunction : coarse

  always_comb begin
    volts_dec = `APPB_V200_0;
    if (cls400) begin
      unique case (rg(st_ff, `APPB_ADDR_VREG_SEL))
        16'h0: volts_dec = `APPB_V400_0;
        16'h1: volts_dec = `APPB_V400_1;
        16'h2: volts_dec = `APPB_V400_2;
        16'h3: volts_dec = `APPB_V400_3;
        16'h4: volts_dec = `APPB_V400_4;
        default: volts_dec = `APPB_V400_5;
      endcase
    end else begin
      unique case (rg(st_ff, `APPB_ADDR_VREG_SEL))
        16'h0: volts_dec = `APPB_V200_0;
        16'h1: volts_dec = `APPB_V200_1;
        16'h2: volts_dec = `APPB_V200_2;
        16'h3: volts_dec = `APPB_V200_3;
        // A code kept from the 400 V class saturates at the top step
        default: volts_dec = `APPB_V200_4;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Current-input scaling
  // ---------------------------------------------------------------
  logic signed [31:0] fs;
  logic signed [31:0] fe;
  logic signed [31:0] ps;
  logic signed [31:0] pe;
  logic signed [31:0] pc;
  logic signed [31:0] interp;
  logic [11:0] scale_dec;

  assign fs = $signed({16'h0, rg(st_ff, `APPB_ADDR_CI_FS)});
  assign fe = $signed({16'h0, rg(st_ff, `APPB_ADDR_CI_FE)});
  assign ps = $signed({16'h0, rg(st_ff, `APPB_ADDR_CI_PS)});
  assign pe = $signed({16'h0, rg(st_ff, `APPB_ADDR_CI_PE)});
  assign pc = $signed({25'h0, current_input_terminal});

  always_comb begin
    interp = fs;
    scale_dec = fs[11:0];
    if (pc < ps) begin
      scale_dec = (rg(st_ff, `APPB_ADDR_CI_SSEL) == 16'h1) ? 12'h0 : fs[11:0];
    end else if (pc >= pe) begin
      // An empty or inverted range gives the end frequency for inputs at or above the start
      scale_dec = fe[11:0];
    end else begin
      interp = fs + ((fe - fs) * (pc - ps)) / (pe - ps);
      scale_dec = interp[11:0];
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.term_sync = {st_ff.term_sync[0], profile_select_terminal};
    nxt_st.class_sync = {st_ff.class_sync[0], class_400_pin};
    if (wr && mapped && wr_ok) begin
      if (addr == `APPB_ADDR_CALC_A) begin
        nxt_st.calc_src = wdata;
      end else begin
        nxt_st.regs[idx(addr)] = wdata;
      end
    end
    nxt_st.rdata = 16'h0;
    if (rd && mapped) begin
      nxt_st.rdata = (addr == `APPB_ADDR_CALC_A) ? st_ff.calc_src : st_ff.regs[idx(addr)];
    end
    nxt_st.volts = volts_dec;
    nxt_st.second_accel_profile_time = coarse(second_accel_profile_raw);
    nxt_st.second_decel_profile_time = coarse(second_decel_profile_raw);
    if (sw_method == 16'h0) begin
      nxt_st.use_second_accel_profile = st_ff.term_sync[1];
      nxt_st.use_second_decel_profile = st_ff.term_sync[1];
    end else begin
      nxt_st.use_second_accel_profile = {4'h0, out_freq} >= acc_tr;
      // Falling frequency crosses the decel point from above
      nxt_st.use_second_decel_profile = {4'h0, out_freq} < dec_tr;
    end
    nxt_st.scaled_freq = scale_dec;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= RST_STATE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rdata = st_ff.rdata;
  assign regulation_active = rg(st_ff, `APPB_ADDR_VREG_MODE) != 16'h1;
  assign regulation_off_in_decel = rg(st_ff, `APPB_ADDR_VREG_MODE) == 16'h2;
  assign regulated_volts = st_ff.volts;
  assign second_accel_time = st_ff.second_accel_profile_time;
  assign second_decel_time = st_ff.second_decel_profile_time;
  assign use_second_accel = st_ff.use_second_accel_profile;
  assign use_second_decel = st_ff.use_second_decel_profile;
  assign accel_s_curve = rg(st_ff, `APPB_ADDR_ACC_CURVE) == 16'h1;
  assign decel_s_curve = rg(st_ff, `APPB_ADDR_DEC_CURVE) == 16'h1;
  assign scaled_freq = st_ff.scaled_freq;
  assign first_operand_source = 5'h1 << st_ff.calc_src[2:0];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_mode_reject: assert property (wr && addr == `APPB_ADDR_VREG_MODE && wdata > 16'h2
    |=> $stable(rg(st_ff, `APPB_ADDR_VREG_MODE)))
    else $error("out-of-range mode write changed the register");

  a_mode_off: assert property (wr && addr == `APPB_ADDR_VREG_MODE && wdata == 16'h1
    |=> !regulation_active && !regulation_off_in_decel)
    else $error("mode 1 did not turn regulation off");

  a_volt_200: assert property (!cls400 && $stable(cls400)
    && rg(st_ff, `APPB_ADDR_VREG_SEL) == 16'h2 |=> regulated_volts == 9'hdc)
    else $error("200 V class code 2 not 220 V");

  a_volt_400: assert property (cls400 && rg(st_ff, `APPB_ADDR_VREG_SEL) == 16'h5
    |=> regulated_volts == 9'h1e0)
    else $error("400 V class code 5 not 480 V");

  a_second_accel_profile_range: assert property ({rg(st_ff, `APPB_ADDR_SECOND_ACCEL_PROFILE_HI_M1),
    rg(st_ff, `APPB_ADDR_SECOND_ACCEL_PROFILE_LO_M1)} inside {[32'h1:32'h493e0]})
    else $error("motor 1 second accel time out of range");

  a_second_accel_profile_m2_out: assert property (motor2_sel && $stable(motor2_sel) ##0
    second_accel_profile_raw < 32'h2710 |=> second_accel_time == $past(second_accel_profile_raw[18:0]))
    else $error("motor 2 second accel time not presented");

  a_second_decel_profile_range: assert property ({rg(st_ff, `APPB_ADDR_SECOND_DECEL_PROFILE_HI_M2),
    rg(st_ff, `APPB_ADDR_SECOND_DECEL_PROFILE_LO_M2)} inside {[32'h1:32'h493e0]})
    else $error("motor 2 second decel time out of range");

  a_freq_switch: assert property (sw_method == 16'h1 && {4'h0, out_freq} >= acc_tr
    |=> use_second_accel)
    else $error("accel profile did not switch at transition");

  a_term_switch: assert property ((sw_method == 16'h0 && profile_select_terminal)[*3]
    |=> use_second_accel && use_second_decel)
    else $error("terminal did not select second profile");

  a_below_zero: assert property (pc < ps && rg(st_ff, `APPB_ADDR_CI_SSEL) == 16'h1
    |=> scaled_freq == 12'h0)
    else $error("below range start not zero hertz");

  a_pct_limit: assert property (rg(st_ff, `APPB_ADDR_CI_PE) <= 16'h64)
    else $error("range end percent above 100");

  a_coarse_time: assert property (second_accel_profile_raw >= 32'h2710
    |=> second_accel_time % 19'ha == 19'h0)
    else $error("long ramp kept its hundredths digit");

  a_src_current: assert property (wr && addr == `APPB_ADDR_CALC_A && wdata == 16'h3
    |=> first_operand_source == 5'h8)
    else $error("operand source 3 not current input");

endmodule : appb_bank

// ### tb/appb_master.sv
/*
  Register-port master standing in for the network master of the parameter bank.
  Assumes its tasks are called from one bench process, just after a clock edge.
*/
module appb_master (
  input wire logic clk,
  output logic [7:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end

  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  // Random idle cycles give the bank slow masters as well as prompt ones
  task automatic idle();
    int n;
    n = $urandom_range(0, 1);
    repeat (n) @(posedge clk);
  endtask : idle

  // Whole 16-bit words only; a time value goes as two separate word writes
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    idle();
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
    #1;
  endtask : wr_reg

  // Address is scrambled once released so stale values never look valid
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    idle();
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask : rd_reg
endmodule : appb_master

// ### tb/tb_appb_bank.sv
/*
  Self-checking bench of the parameter bank: reset values, ranges, decoding,
  profile switching and current-input scaling, random values among corner cases.
  Assumes appb_params.svh on the include path and appb_pkg compiled first.
*/
`include "appb_params.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fails++; \
  $display("unexpected at %0t: got %h exp %h", $time, (got), (exp)); end end
module tb_appb_bank import appb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst_n, wr, rd;
  logic [7:0] addr;
  logic [15:0] wdata, rdata;
  logic class_400_pin, profile_select_terminal, motor2_sel;
  logic [11:0] out_freq, scaled_freq;
  logic [6:0] current_input_terminal;
  logic regulation_active, regulation_off_in_decel, use_second_accel, use_second_decel;
  logic accel_s_curve, decel_s_curve;
  logic [8:0] regulated_volts;
  logic [18:0] second_accel_time, second_decel_time;
  logic [4:0] first_operand_source;
  int fails = 0;
  int n_checks = 0;
  appb_word_t d, sh;

  appb_bank appb_bank_inst (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .class_400_pin,
    .profile_select_terminal, .motor2_sel, .out_freq, .current_input_terminal,
    .regulation_active, .regulation_off_in_decel, .regulated_volts, .second_accel_time,
    .second_decel_time, .use_second_accel, .use_second_decel, .accel_s_curve,
    .decel_s_curve, .scaled_freq, .first_operand_source);
  appb_master appb_master_inst (.clk, .addr, .wdata, .wr, .rd, .rdata);

  // ---------------------------------------------------------------
  // Expectations and helpers
  // ---------------------------------------------------------------
  function automatic int rst_val(int a);
    if (a inside {8'h75, 8'h77, 8'h79, 8'h7b}) return 1000;
    if (a == 8'h87) return 100;
    return 0;
  endfunction : rst_val

  function automatic int rnd_time(int v);
    return (v >= 10000) ? v - v % 10 : v;
  endfunction : rnd_time

  function automatic int scale(int fs, int fe, int ps, int pe, int c, int sel);
    // Below the start wins even when the range is inverted
    if (c < ps) return sel ? 0 : fs;
    if (c >= pe) return fe;
    if (c == ps) return fs;
    return fs + (fe - fs) * (c - ps) / (pe - ps);
  endfunction : scale

  task automatic settle(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  // A refused write must leave the old word in place
  task automatic wr_chk(input int a, input int v, input int old, input bit ok);
    appb_master_inst.wr_reg(8'(a), 16'(v));
    appb_master_inst.rd_reg(8'(a), d);
    sh = ok ? 16'(v) : 16'(old);
    `CHK(d, sh)
  endtask : wr_chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  // ---------------------------------------------------------------
  // Clock, watchdog and tests
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude();
  end

  initial begin
    int i, m, a, f, c, fs, fe, ps, pe, sel;
    int v200[5] = '{200, 215, 220, 230, 240};
    int v400[6] = '{380, 400, 415, 440, 460, 480};
    int fq[4] = '{1000, 1001, 500, 499};
    rst_n = 1'b0;
    class_400_pin = 1'b0;
    profile_select_terminal = 1'b0;
    motor2_sel = 1'b0;
    out_freq = 12'h000;
    current_input_terminal = 7'h00;
    void'($urandom(32'h658b));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    settle(1);
    for (i = 8'h72; i <= 8'h89; i++) begin
      a = (i == 8'h89) ? 8'he3 : i;
      appb_master_inst.rd_reg(8'(a), d);
      `CHK(d, rst_val(a))
    end
    `CHK(regulated_volts, 200)
    `CHK(second_accel_time, 1000)
    appb_master_inst.wr_reg(8'h89, 16'h1234);
    appb_master_inst.rd_reg(8'h89, d);
    `CHK(d, 0)
    settle(1);
    `CHK(rdata, 0)
    sh = 0;
    for (i = 0; i < 4; i++) begin
      wr_chk(`APPB_ADDR_VREG_MODE, i, sh, i <= 2);
      `CHK(regulation_active, sh != 1)
      `CHK(regulation_off_in_decel, sh == 2)
    end
    sh = 0;
    for (m = 0; m < 2; m++) begin
      class_400_pin <= m[0];
      settle(4);
      for (i = 0; i < 7; i++) begin
        wr_chk(`APPB_ADDR_VREG_SEL, i, sh, i <= 4 + m);
        settle(1);
        `CHK(regulated_volts, m ? v400[sh] : v200[sh])
      end
    end
    // Each half is judged against the other stored half, so order matters
    for (m = 0; m < 4; m++) begin
      motor2_sel <= m[0];
      a = 8'h74 + 2 * m;
      appb_master_inst.wr_reg(8'(a), 16'h0000);
      wr_chk(a + 1, 16'h2715, 1000, 1);
      settle(2);
      `CHK(m < 2 ? second_accel_time : second_decel_time, rnd_time(10005))
      appb_master_inst.wr_reg(8'(a), 16'h0004);
      wr_chk(a + 1, 16'h93e1, 16'h2715, 0);
      wr_chk(a + 1, 16'h93e0, 16'h2715, 1);
      wr_chk(a, 16'h0005, 4, 0);
      settle(2);
      `CHK(m < 2 ? second_accel_time : second_decel_time, 300000)
      wr_chk(a, 0, 4, 1);
      wr_chk(a + 1, 0, 16'h93e0, 0);
      settle(2);
      `CHK(m < 2 ? second_accel_time : second_decel_time, rnd_time(16'h93e0))
    end
    for (m = 0; m < 2; m++) begin
      motor2_sel <= m[0];
      wr_chk(8'h7c + m, 2, 0, 0);
      for (i = 0; i < 2; i++) begin
        profile_select_terminal <= i[0];
        settle(4);
        `CHK(use_second_accel, i[0])
        `CHK(use_second_decel, i[0])
      end
      wr_chk(8'h7c + m, 1, 0, 1);
      wr_chk(8'h7e + m, 1000 + m, 0, 1);
      wr_chk(8'h80 + m, 500 + m, 0, 1);
      for (i = 0; i < 4; i++) begin
        out_freq <= 12'(fq[i]);
        settle(2);
        `CHK(use_second_accel, fq[i] >= 1000 + m)
        `CHK(use_second_decel, fq[i] < 500 + m)
      end
    end
    for (i = 0; i < 3; i++) begin
      wr_chk(`APPB_ADDR_ACC_CURVE, i, i / 2, i < 2);
      `CHK(accel_s_curve, sh == 1)
      wr_chk(`APPB_ADDR_DEC_CURVE, i, i / 2, i < 2);
      `CHK(decel_s_curve, sh == 1)
    end
    sh = 0;
    for (i = 0; i < 6; i++) begin
      wr_chk(`APPB_ADDR_CALC_A, i, sh, i <= 4);
      `CHK(first_operand_source, 5'h01 << sh)
    end
    fs = 0;
    fe = 0;
    ps = 0;
    pe = 100;
    sel = 0;
    for (i = 0; i < 40; i++) begin
      f = $urandom_range(0, 4100);
      wr_chk(`APPB_ADDR_CI_FS, f, fs, f <= 4000);
      fs = sh;
      f = $urandom_range(0, 4100);
      wr_chk(`APPB_ADDR_CI_FE, f, fe, f <= 4000);
      fe = sh;
      f = $urandom_range(0, 104);
      wr_chk(`APPB_ADDR_CI_PS, f, ps, f <= 100);
      ps = sh;
      f = $urandom_range(0, 104);
      wr_chk(`APPB_ADDR_CI_PE, f, pe, f <= 100);
      pe = sh;
      wr_chk(`APPB_ADDR_CI_SSEL, i % 3, sel, i % 3 < 2);
      sel = sh;
      c = (i % 4 == 0) ? ps : $urandom_range(0, 100);
      current_input_terminal <= 7'(c);
      settle(2);
      `CHK(scaled_freq, 12'(scale(fs, fe, ps, pe, c, sel)))
    end
    conclude();
  end
endmodule : tb_appb_bank
